// file: hdl/fgr_pkg.sv
package fgr_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam logic [7:0] REG_INTERVAL = 8'h0C;
    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TCR_BIT = 3;
    localparam int CTRL_TEMP_LSB = 4;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // status register bits
    localparam int ST_BUSY = 0;
    localparam int ST_IN_SR = 1;
    localparam int ST_EXTRA = 2;
    localparam int ST_ERR_CFG = 3;
    localparam int ST_ERR_PAR = 4;
    localparam int ST_ERR_BUSY = 5;
    // refresh rate mode field codes
    localparam logic [2:0] MODE_FIXED_1X = 3'h0;
    localparam logic [2:0] MODE_FIXED_2X = 3'h1;
    localparam logic [2:0] MODE_FIXED_4X = 3'h2;
    localparam logic [2:0] MODE_OTF_1X2X = 3'h5;
    localparam logic [2:0] MODE_OTF_1X4X = 3'h6;
    // extra refreshes owed after self refresh exit
    localparam logic [2:0] EXTRA_2X = 3'h2;
    localparam logic [2:0] EXTRA_4X = 3'h4;
    // timing, printed figures and derived cycle counts
    localparam int CLK_PERIOD_NS = 4;
    localparam int BASE_INTERVAL_NS = 7800;
    localparam int RFC1_NS = 350;
    localparam int RFC2_NS = 260;
    localparam int RFC4_NS = 160;
    localparam int BASE_INTERVAL_CYC = BASE_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int RFC1_CYC = (RFC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RFC2_CYC = (RFC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RFC4_CYC = (RFC4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // refresh rate of a command or of a mode family
    typedef enum logic [1:0] {FGR_RATE_1X, FGR_RATE_2X, FGR_RATE_4X} fgr_rate_e;
endpackage

// file: hdl/fgr_cycle_timer.sv
`timescale 1ns/1ps
// down counter holding busy for exactly load_i cycles after start_i
module fgr_cycle_timer #(
    parameter int W = 7
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic [W-1:0] load_i,
    output logic busy_o
);
    logic [W-1:0] cnt_q; // cycles left
    logic [W-1:0] cnt_d;
    logic busy_q;
    logic busy_d;

    // next count: load wins, else count down to zero
    always_comb begin
        cnt_d = cnt_q;
        if (start_i) begin
            cnt_d = load_i;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
        busy_d = (cnt_d != '0);
    end

    // registered so busy_o is a clean flop output
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end

    assign busy_o = busy_q;
endmodule

// file: hdl/fgr_refresh.sv
`timescale 1ns/1ps
// Operation
// - mode field codes; reserved codes refused
// - on-the-fly: bank group bit picks rate
// - cycle time 350/260/160 ns per rate
// - new timing applies at rate change
// - each refresh imposes its own timing
// - fixed 1x free; same-rate switch no change
// - self refresh entry accepted in any mode
module fgr_refresh (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic link_ck_i, // command clock from the controller
    input wire logic ref_cmd_i, // refresh command on the link
    input wire logic bank_group0_i, // rate select in on-the-fly modes
    input wire logic sr_entry_i, // self refresh entry command
    input wire logic sr_exit_i, // self refresh exit command
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic busy_o, // refresh cycle time running
    output logic [1:0] rate_o, // rate now in force
    output logic extra_owed_o // extra refreshes still owed
);
    localparam int A_RFC1 = fgr_pkg::RFC1_CYC;
    localparam int A_RFC4 = fgr_pkg::RFC4_CYC;

    // two-flop synchronisers; stage 1 feeds stage 2 only
    logic ck_s1_q, ck_s2_q, ck_s3_q;
    logic [3:0] cmd_s1_q, cmd_s2_q;
    logic link_edge;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
            cmd_s1_q <= 4'h0;
            cmd_s2_q <= 4'h0;
        end else begin
            ck_s1_q <= link_ck_i;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
            cmd_s1_q <= {sr_exit_i, sr_entry_i, bank_group0_i, ref_cmd_i};
            cmd_s2_q <= cmd_s1_q;
        end
    end

    // commands sampled on the synced rising link edge; both paths have equal delay
    assign link_edge = ck_s2_q & ~ck_s3_q;

    // rate family of a mode code
    function automatic fgr_pkg::fgr_rate_e family_of(input logic [2:0] m);
        unique case (m)
            fgr_pkg::MODE_FIXED_2X, fgr_pkg::MODE_OTF_1X2X: family_of = fgr_pkg::FGR_RATE_2X;
            fgr_pkg::MODE_FIXED_4X, fgr_pkg::MODE_OTF_1X4X: family_of = fgr_pkg::FGR_RATE_4X;
            default: family_of = fgr_pkg::FGR_RATE_1X;
        endcase
    endfunction

    // fine refresh count not on a whole base-rate boundary
    function automatic logic misaligned(input fgr_pkg::fgr_rate_e f, input logic [7:0] c);
        unique case (f)
            fgr_pkg::FGR_RATE_2X: misaligned = c[0];
            fgr_pkg::FGR_RATE_4X: misaligned = (c[1:0] != 2'h0);
            default: misaligned = 1'b0;
        endcase
    endfunction

    logic [2:0] mode_q, mode_d; // refresh_rate_mode_field
    logic tcr_q, tcr_d; // temp_controlled_refresh enable
    logic [1:0] temp_q, temp_d; // case temperature band
    fgr_pkg::fgr_rate_e rate_q, rate_d; // rate in force
    logic [7:0] count_q, count_d; // fine refreshes since reset point
    logic [2:0] extra_q, extra_d; // extra refreshes left after exit
    logic in_sr_q, in_sr_d, extra_owed_q, extra_owed_d; // owed flag kept in a flop for the pin
    logic err_cfg_q, err_cfg_d, err_par_q, err_par_d, err_busy_q, err_busy_d;
    logic [11:0] interval_q, interval_d; // avg_refresh_interval in cycles
    logic [31:0] rdata_q, rdata_d;
    logic timer_start;
    logic [6:0] timer_load;
    logic busy;
    logic ref_ev, sre_ev, srx_ev, on_the_fly_rate_select, cfg_wr, cfg_ok;
    logic [2:0] new_mode;
    fgr_pkg::fgr_rate_e cmd_rate;

    assign on_the_fly_rate_select = mode_q[2];
    assign ref_ev = link_edge & cmd_s2_q[0] & ~in_sr_q;
    assign sre_ev = link_edge & cmd_s2_q[2] & ~in_sr_q;
    assign srx_ev = link_edge & cmd_s2_q[3] & in_sr_q;
    assign cfg_wr = wr_i & (addr_i == fgr_pkg::REG_CTRL);
    assign new_mode = wdata_i[fgr_pkg::CTRL_MODE_LSB +: 3];
    // reserved codes and non-1x with tcr on are refused whole
    assign cfg_ok = (new_mode == fgr_pkg::MODE_FIXED_1X || new_mode == fgr_pkg::MODE_FIXED_2X
        || new_mode == fgr_pkg::MODE_FIXED_4X || new_mode == fgr_pkg::MODE_OTF_1X2X
        || new_mode == fgr_pkg::MODE_OTF_1X4X)
        && !(wdata_i[fgr_pkg::CTRL_TCR_BIT] && new_mode != fgr_pkg::MODE_FIXED_1X);

    // in on-the-fly modes bank group bit 0 selects fine rate, fixed modes ignore it
    assign cmd_rate = (on_the_fly_rate_select && !cmd_s2_q[1]) ? fgr_pkg::FGR_RATE_1X : family_of(mode_q);

    // each accepted refresh loads its own cycle time; a same-cycle control write drops it
    always_comb begin
        timer_start = ref_ev & ~busy & ~cfg_wr;
        unique case (cmd_rate)
            fgr_pkg::FGR_RATE_2X: timer_load = 7'(fgr_pkg::RFC2_CYC);
            fgr_pkg::FGR_RATE_4X: timer_load = 7'(fgr_pkg::RFC4_CYC);
            default: timer_load = 7'(fgr_pkg::RFC1_CYC);
        endcase
    end

    fgr_cycle_timer #(.W(7)) u_timer (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .start_i(timer_start),
        .load_i(timer_load),
        .busy_o(busy)
    );

    // mode, counters, self refresh tracking and sticky flags
    always_comb begin
        mode_d = mode_q;
        tcr_d = tcr_q;
        temp_d = temp_q;
        rate_d = rate_q;
        count_d = count_q;
        extra_d = extra_q;
        in_sr_d = in_sr_q;
        err_cfg_d = err_cfg_q;
        err_par_d = err_par_q;
        err_busy_d = err_busy_q;
        // write-one-to-clear first, so a same-cycle event still sets
        if (wr_i && addr_i == fgr_pkg::REG_STATUS) begin
            err_cfg_d = err_cfg_q & ~wdata_i[fgr_pkg::ST_ERR_CFG];
            err_par_d = err_par_q & ~wdata_i[fgr_pkg::ST_ERR_PAR];
            err_busy_d = err_busy_q & ~wdata_i[fgr_pkg::ST_ERR_BUSY];
        end
        if (cfg_wr) begin
            if (!cfg_ok) begin
                err_cfg_d = 1'b1;
            end else begin
                mode_d = new_mode;
                tcr_d = wdata_i[fgr_pkg::CTRL_TCR_BIT];
                temp_d = wdata_i[fgr_pkg::CTRL_TEMP_LSB +: 2];
                // same family is no rate change; fixed 1x never misaligned
                if (family_of(new_mode) != family_of(mode_q)) begin
                    if (misaligned(family_of(mode_q), count_q)) begin
                        err_par_d = 1'b1;
                    end
                    count_d = 8'h00;
                end
                rate_d = family_of(new_mode);
            end
        end else if (ref_ev) begin
            if (busy) begin
                err_busy_d = 1'b1; // refused inside the cycle time
            end else begin
                rate_d = cmd_rate;
                if (extra_q != 3'h0) begin
                    // owed extras stay out of the count
                    extra_d = (cmd_rate == fgr_pkg::FGR_RATE_1X) ? 3'h0 : extra_q - 3'h1;
                end else if (cmd_rate == fgr_pkg::FGR_RATE_1X) begin
                    if (on_the_fly_rate_select && misaligned(family_of(mode_q), count_q)) begin
                        err_par_d = 1'b1;
                    end
                    count_d = 8'h00;
                end else begin
                    count_d = count_q + 8'h01;
                end
            end
        end else if (sre_ev) begin
            in_sr_d = 1'b1;
        end else if (srx_ev) begin
            in_sr_d = 1'b0;
            if (misaligned(family_of(mode_q), count_q)) begin
                extra_d = (family_of(mode_q) == fgr_pkg::FGR_RATE_2X) ?
                    fgr_pkg::EXTRA_2X : fgr_pkg::EXTRA_4X;
            end
            count_d = 8'h00;
        end
        extra_owed_d = (extra_d != 3'h0); // flag tracks the owed count
    end

    // required interval: base over rate, halved per temperature band
    always_comb begin
        interval_d = 12'(fgr_pkg::BASE_INTERVAL_CYC) >> (int'(rate_q) + int'(temp_q));
    end

    // register reads, data valid the cycle after the strobe only
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_i) begin
            unique case (addr_i)
                fgr_pkg::REG_CTRL: rdata_d = {26'h000_0000, temp_q, tcr_q, mode_q};
                fgr_pkg::REG_STATUS: rdata_d = {26'h000_0000, err_busy_q, err_par_q,
                    err_cfg_q, (extra_q != 3'h0), in_sr_q, busy};
                fgr_pkg::REG_COUNT: rdata_d = {19'h0_0000, extra_q, 2'(rate_q), count_q};
                fgr_pkg::REG_INTERVAL: rdata_d = {20'h0_0000, interval_q};
                default: rdata_d = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            mode_q <= fgr_pkg::CTRL_RESET[2:0];
            tcr_q <= fgr_pkg::CTRL_RESET[3];
            temp_q <= fgr_pkg::CTRL_RESET[5:4];
            rate_q <= fgr_pkg::FGR_RATE_1X;
            count_q <= 8'h00;
            extra_q <= 3'h0;
            in_sr_q <= 1'b0;
            extra_owed_q <= 1'b0;
            err_cfg_q <= 1'b0;
            err_par_q <= 1'b0;
            err_busy_q <= 1'b0;
            interval_q <= 12'h000;
            rdata_q <= 32'h0000_0000;
        end else begin
            mode_q <= mode_d;
            tcr_q <= tcr_d;
            temp_q <= temp_d;
            rate_q <= rate_d;
            count_q <= count_d;
            extra_q <= extra_d;
            in_sr_q <= in_sr_d;
            extra_owed_q <= extra_owed_d;
            err_cfg_q <= err_cfg_d;
            err_par_q <= err_par_d;
            err_busy_q <= err_busy_d;
            interval_q <= interval_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign busy_o = busy;
    assign rate_o = 2'(rate_q);
    assign extra_owed_o = extra_owed_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    cfg_refuse_a: assert property (cfg_wr && !cfg_ok |=> $stable(mode_q) && err_cfg_q)
        else $error("refused mode write changed mode");
    tcr_mode_a: assert property (tcr_q |-> mode_q == fgr_pkg::MODE_FIXED_1X)
        else $error("tcr enabled outside fixed 1x");
    single_cycle_a: assert property (timer_start && cmd_rate == fgr_pkg::FGR_RATE_1X
        |-> ##A_RFC1 busy_o ##1 !busy_o)
        else $error("single-rate cycle time wrong");
    quad_cycle_a: assert property (timer_start && cmd_rate == fgr_pkg::FGR_RATE_4X
        |-> ##A_RFC4 busy_o ##1 !busy_o)
        else $error("quad-rate cycle time wrong");
    otf_select_a: assert property (timer_start && on_the_fly_rate_select && cmd_s2_q[1]
        |=> rate_q == family_of($past(mode_q)))
        else $error("on-the-fly rate select wrong");
    count_clear_a: assert property (timer_start && extra_q == 3'h0
        && cmd_rate == fgr_pkg::FGR_RATE_1X |=> count_q == 8'h00)
        else $error("single-rate refresh left count");
    rate_par_a: assert property (cfg_wr && cfg_ok && family_of(new_mode) != family_of(mode_q)
        && misaligned(family_of(mode_q), count_q) |=> err_par_q)
        else $error("misaligned rate change not flagged");
    extra_owed_a: assert property (srx_ev && family_of(mode_q) == fgr_pkg::FGR_RATE_2X
        && count_q[0] && !cfg_wr |=> extra_q == fgr_pkg::EXTRA_2X && !in_sr_q)
        else $error("extra refreshes not owed after exit");
    sr_accept_a: assert property (sre_ev && !cfg_wr |=> in_sr_q ##1 (in_sr_q || $past(srx_ev)))
        else $error("self refresh entry refused");
endmodule

// file: sim/fgr_ctrl_model.sv
`timescale 1ns/1ps
// controller side of the command link: one link clock pulse per command frame
module fgr_ctrl_model (
    output logic link_ck_o, // stands still low between frames
    output logic ref_cmd_o,
    output logic bank_group0_o,
    output logic sr_entry_o,
    output logic sr_exit_o
);
    initial begin
        link_ck_o = 1'b0;
        ref_cmd_o = 1'b0;
        bank_group0_o = 1'b0;
        sr_entry_o = 1'b0;
        sr_exit_o = 1'b0;
    end

    // one frame of 73 ns: pins set a half link period before the rising edge
    // pins settle 8 sys cycles before the rising edge and hold 10 after it, well past the sync window
    task automatic frame(input logic rf, input logic bg, input logic ent, input logic ex);
        #1; // keeps link edges off the system clock edge, and back-to-back frames apart
        ref_cmd_o = rf;
        bank_group0_o = bg;
        sr_entry_o = ent;
        sr_exit_o = ex;
        #32 link_ck_o = 1'b1;
        #32 link_ck_o = 1'b0;
        #8;
        // released lines are not left showing the old command
        ref_cmd_o = ~rf;
        bank_group0_o = ~bg;
        sr_entry_o = ~ent;
        sr_exit_o = ~ex;
    endtask
endmodule

// file: sim/test_fine_granularity_refresh.sv
`timescale 1ns/1ps
// self-checking bench: register port driven here, link driven by the model
module test_fine_granularity_refresh;
    logic clk_sys_i, reset_i, wr_i, rd_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, rv;
    logic busy_o, extra_owed_o;
    logic [1:0] rate_o;
    logic link_ck, ref_cmd, bg0, sr_ent, sr_ex;
    int error_cnt = 0;
    int checked = 0;
    int n;

    fgr_ctrl_model model_u (.link_ck_o(link_ck), .ref_cmd_o(ref_cmd),
        .bank_group0_o(bg0), .sr_entry_o(sr_ent), .sr_exit_o(sr_ex));
    fgr_refresh dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link_ck_i(link_ck),
        .ref_cmd_i(ref_cmd), .bank_group0_i(bg0), .sr_entry_i(sr_ent), .sr_exit_i(sr_ex),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .busy_o(busy_o), .rate_o(rate_o), .extra_owed_o(extra_owed_o));

    // 250 mhz system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    // read data only stands in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
    endtask

    // control word: band, temperature-controlled enable, mode
    function automatic logic [31:0] ctl(input logic [1:0] band, input logic temp_controlled_refresh,
                                        input logic [2:0] mode);
        return {26'h000_0000, band, temp_controlled_refresh, mode};
    endfunction

    // counts cycles busy stays high, bounded waits on both sides
    task automatic busy_len();
        n = 0;
        for (int i = 0; i < 60 && busy_o !== 1'b1; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        while (busy_o === 1'b1 && n < 200) begin
            n++;
            @(posedge clk_sys_i);
            #1;
        end
    endtask

    // one refresh frame and its busy span
    task automatic refresh(input logic bg, input int exp_len, input string what);
        fork
            model_u.frame(1'b1, bg, 1'b0, 1'b0);
            busy_len();
        join
        check(what, n, exp_len);
    endtask

    task automatic t_reset();
        rd(fgr_pkg::REG_CTRL);
        check("ctrl reset", rv, 32'h0000_0000);
        rd(fgr_pkg::REG_STATUS);
        check("status reset", rv, 32'h0000_0000);
        rd(fgr_pkg::REG_INTERVAL);
        check("interval 1x", rv, fgr_pkg::BASE_INTERVAL_CYC);
        rd(8'h10);
        check("unmapped read", rv, 32'h0000_0000);
        $display("test reset done");
    endtask

    // fixed modes: cycle time and rate per mode, odd fine count before change
    task automatic t_fixed();
        logic [2:0] modes [3] = '{fgr_pkg::MODE_FIXED_1X, fgr_pkg::MODE_FIXED_2X,
                                  fgr_pkg::MODE_FIXED_4X};
        int lens [3] = '{fgr_pkg::RFC1_CYC, fgr_pkg::RFC2_CYC, fgr_pkg::RFC4_CYC};
        for (int i = 0; i < 3; i++) begin
            wr(fgr_pkg::REG_CTRL, ctl(2'h0, 1'b0, modes[i]));
            rd(fgr_pkg::REG_INTERVAL);
            check("interval", rv, fgr_pkg::BASE_INTERVAL_CYC >> i);
            refresh(1'b1, lens[i], "busy span");
            check("rate", 32'(rate_o), i);
        end
        rd(fgr_pkg::REG_STATUS);
        check("parity after odd 2x", 32'(rv[fgr_pkg::ST_ERR_PAR]), 1);
        wr(fgr_pkg::REG_STATUS, 32'h0000_0038);
        // same family switch is no rate change
        wr(fgr_pkg::REG_CTRL, ctl(2'h0, 1'b0, fgr_pkg::MODE_OTF_1X4X));
        rd(fgr_pkg::REG_STATUS);
        check("same family", 32'(rv[fgr_pkg::ST_ERR_PAR]), 0);
        // single-rate after one quad-rate refresh breaks the multiple of four
        refresh(1'b0, fgr_pkg::RFC1_CYC, "otf 1x span");
        check("otf 1x rate", 32'(rate_o), 0);
        rd(fgr_pkg::REG_STATUS);
        check("parity 4x", 32'(rv[fgr_pkg::ST_ERR_PAR]), 1);
        wr(fgr_pkg::REG_STATUS, 32'h0000_0038);
        $display("test fixed and on-the-fly done");
    endtask

    task automatic t_cfg();
        wr(fgr_pkg::REG_CTRL, ctl(2'h3, 1'b0, fgr_pkg::MODE_FIXED_4X));
        rd(fgr_pkg::REG_INTERVAL);
        check("hot interval", rv, fgr_pkg::BASE_INTERVAL_CYC >> 5);
        // reserved code, then tcr with a fine mode: both refused
        wr(fgr_pkg::REG_CTRL, ctl(2'h0, 1'b0, 3'h3));
        wr(fgr_pkg::REG_STATUS, 32'h0000_0000);
        rd(fgr_pkg::REG_STATUS);
        check("reserved refused", 32'(rv[fgr_pkg::ST_ERR_CFG]), 1);
        wr(fgr_pkg::REG_STATUS, 32'h0000_0038);
        wr(fgr_pkg::REG_CTRL, ctl(2'h0, 1'b1, fgr_pkg::MODE_FIXED_2X));
        rd(fgr_pkg::REG_STATUS);
        check("tcr refused", 32'(rv[fgr_pkg::ST_ERR_CFG]), 1);
        rd(fgr_pkg::REG_CTRL);
        check("ctrl kept", rv, ctl(2'h3, 1'b0, fgr_pkg::MODE_FIXED_4X));
        wr(fgr_pkg::REG_STATUS, 32'h0000_0038);
        // second refresh inside the busy span is dropped
        wr(fgr_pkg::REG_CTRL, ctl(2'h0, 1'b0, fgr_pkg::MODE_FIXED_1X));
        fork
            begin
                model_u.frame(1'b1, 1'b0, 1'b0, 1'b0);
                model_u.frame(1'b1, 1'b0, 1'b0, 1'b0);
            end
            busy_len();
        join
        check("busy span kept", n, fgr_pkg::RFC1_CYC);
        rd(fgr_pkg::REG_STATUS);
        check("busy refused", 32'(rv[fgr_pkg::ST_ERR_BUSY]), 1);
        $display("test config done");
    endtask

    task automatic t_self_refresh();
        wr(fgr_pkg::REG_CTRL, ctl(2'h0, 1'b0, fgr_pkg::MODE_FIXED_2X));
        refresh(1'b1, fgr_pkg::RFC2_CYC, "2x span");
        model_u.frame(1'b0, 1'b0, 1'b1, 1'b0);
        rd(fgr_pkg::REG_STATUS);
        check("entry on odd count", 32'(rv[fgr_pkg::ST_IN_SR]), 1);
        model_u.frame(1'b0, 1'b0, 1'b0, 1'b1);
        check("extra owed", 32'(extra_owed_o), 1);
        rd(fgr_pkg::REG_COUNT);
        check("extra count", 32'(rv[12:10]), fgr_pkg::EXTRA_2X);
        refresh(1'b1, fgr_pkg::RFC2_CYC, "extra span");
        refresh(1'b1, fgr_pkg::RFC2_CYC, "extra span");
        check("extra paid", 32'(extra_owed_o), 0);
        $display("test self refresh done");
    endtask

    // on-the-fly 1x/2x parity, quad-rate extras after exit, quad-rate rate change
    task automatic t_otf_rules();
        wr(fgr_pkg::REG_STATUS, 32'h0000_0038);
        wr(fgr_pkg::REG_CTRL, ctl(2'h0, 1'b0, fgr_pkg::MODE_OTF_1X2X));
        refresh(1'b1, fgr_pkg::RFC2_CYC, "otf 2x span");
        check("otf 2x rate", 32'(rate_o), 1);
        // single-rate after an odd double-rate count
        refresh(1'b0, fgr_pkg::RFC1_CYC, "otf 1x after 2x span");
        rd(fgr_pkg::REG_STATUS);
        check("parity 2x", 32'(rv[fgr_pkg::ST_ERR_PAR]), 1);
        wr(fgr_pkg::REG_STATUS, 32'h0000_0038);
        // three quad-rate refreshes leave the count off a multiple of four
        wr(fgr_pkg::REG_CTRL, ctl(2'h0, 1'b0, fgr_pkg::MODE_FIXED_4X));
        repeat (3) refresh(1'b1, fgr_pkg::RFC4_CYC, "4x span");
        model_u.frame(1'b0, 1'b0, 1'b1, 1'b0);
        model_u.frame(1'b0, 1'b0, 1'b0, 1'b1);
        rd(fgr_pkg::REG_COUNT);
        check("extra 4x count", 32'(rv[12:10]), fgr_pkg::EXTRA_4X);
        repeat (4) refresh(1'b1, fgr_pkg::RFC4_CYC, "4x extra span");
        rd(fgr_pkg::REG_COUNT);
        check("extras uncounted", 32'({rv[12:10], rv[7:0]}), 0);
        // one more quad-rate refresh, then a rate change by register write
        refresh(1'b1, fgr_pkg::RFC4_CYC, "4x odd span");
        wr(fgr_pkg::REG_CTRL, ctl(2'h0, 1'b0, fgr_pkg::MODE_FIXED_1X));
        rd(fgr_pkg::REG_STATUS);
        check("parity 4x change", 32'(rv[fgr_pkg::ST_ERR_PAR]), 1);
        $display("test on-the-fly rules done");
    endtask

    initial begin
        reset_i = 1'b1;
        addr_i = 8'h00;
        wdata_i = 32'h0000_0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        t_reset();
        t_fixed();
        t_cfg();
        t_self_refresh();
        t_otf_rules();
        tally_and_finish();
    end

    // run needs a few microseconds; this bound leaves wide margin
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
